// >>> design/pprb_defs.svh
// constants for the pattern replay ping-pong buffer
`ifndef PPRB_DEFS_SVH
`define PPRB_DEFS_SVH
`define PPRB_WORD_W      16
`define PPRB_BYTE_LO_MSB 7
`define PPRB_BYTE_HI_LSB 8
`define PPRB_ADDR_W      10
`define PPRB_SAMPLE_W    16
`endif

// >>> design/pprb_mem.sv
// dual-port replay memory with registered read data
`timescale 1ns/1ns
module pprb_mem #(
    parameter int DW = 16,
    parameter int AW = 10
) (
    input  wire logic          sys_clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // pprb_mem

// >>> design/pprb_pkg.sv
// types for the pattern replay ping-pong buffer
package pprb_pkg;
    typedef enum logic [2:0] {PPRB_IDLE, PPRB_ARMED, PPRB_RUN, PPRB_STOPPED} pprb_state_e;
    typedef logic [15:0] pprb_word_t;
endpackage

// >>> design/pprb_top.sv
// replay path: sample packing, two memory channels, ping-pong FIFO replay
`timescale 1ns/1ns
`include "pprb_defs.svh"
module pprb_top
    import pprb_pkg::*;
#(
    parameter int AW = `PPRB_ADDR_W
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        memchan0_byte_samples,
    input  wire logic        memchan1_byte_samples,
    input  wire logic        wr_valid,
    input  wire logic        wr_chan,
    input  wire logic [15:0] wr_sample,
    input  wire logic        refill_done,
    input  wire logic        start,
    input  wire logic        stop,
    input  wire logic        sw_trigger,
    input  wire logic        ext_trigger,
    input  wire logic        gate,
    output logic             out_valid,
    output logic      [15:0] out_word0,
    output logic      [15:0] out_word1,
    output logic             active_half,
    output logic             refill_irq,
    output logic             overrun,
    output logic             running
);
    localparam int HW = AW - 1;

    // external trigger and gate come from pins
    logic trig_s1, trig_s2, gate_s1, gate_s2;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            gate_s1 <= 1'b0;
            gate_s2 <= 1'b0;
        end else begin
            trig_s1 <= ext_trigger;
            trig_s2 <= trig_s1;
            gate_s1 <= gate;
            gate_s2 <= gate_s1;
        end
    end

    // write side: pack samples into 16-bit words per memory channel
    logic [7:0]    lo_byte_reg [0:1];
    logic [1:0]    byte_ph_reg;
    logic [AW-1:0] wptr_reg [0:1];
    wire           wr_byte_mode = wr_chan ? memchan1_byte_samples : memchan0_byte_samples;
    wire           wr_cidx      = wr_chan;
    wire [15:0]    packed_word  = wr_byte_mode
                                ? {wr_sample[`PPRB_BYTE_LO_MSB:0], lo_byte_reg[wr_cidx]}
                                : wr_sample;
    wire           word_done    = wr_valid && (!wr_byte_mode || byte_ph_reg[wr_cidx]);
    wire           mem_we0      = word_done && !wr_chan;
    wire           mem_we1      = word_done &&  wr_chan;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            byte_ph_reg    <= 2'h0;
            lo_byte_reg[0] <= 8'h00;
            lo_byte_reg[1] <= 8'h00;
            wptr_reg[0]    <= '0;
            wptr_reg[1]    <= '0;
        end else if (wr_valid) begin
            if (wr_byte_mode && !byte_ph_reg[wr_cidx]) begin
                lo_byte_reg[wr_cidx] <= wr_sample[7:0];
                byte_ph_reg[wr_cidx] <= 1'b1;
            end else begin
                byte_ph_reg[wr_cidx] <= 1'b0;
                wptr_reg[wr_cidx]    <= wptr_reg[wr_cidx] + 1'b1;
            end
        end
    end

    // replay side
    pprb_state_e   state_reg, state_next;
    logic [HW-1:0] rptr_reg;
    logic          half_reg;
    logic [1:0]    full_reg;
    logic          rd_valid_reg;
    wire [AW-1:0]  rd_addr   = {half_reg, rptr_reg};
    wire           trig      = sw_trigger || trig_s2;
    wire           step      = (state_reg == PPRB_RUN) && gate_s2;
    wire           half_end  = step && (rptr_reg == {HW{1'b1}});
    wire           underrun  = step && !full_reg[half_reg];
    wire [15:0]    rd0, rd1;

    pprb_mem #(.DW(`PPRB_WORD_W), .AW(AW)) u_mem0 (
        .sys_clk (sys_clk),
        .wr_en   (mem_we0),
        .wr_addr (wptr_reg[0]),
        .wr_data (packed_word),
        .rd_addr (rd_addr),
        .rd_data (rd0)
    );
    pprb_mem #(.DW(`PPRB_WORD_W), .AW(AW)) u_mem1 (
        .sys_clk (sys_clk),
        .wr_en   (mem_we1),
        .wr_addr (wptr_reg[1]),
        .wr_data (packed_word),
        .rd_addr (rd_addr),
        .rd_data (rd1)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PPRB_IDLE:    if (start) state_next = PPRB_ARMED;
            PPRB_ARMED:   if (stop) state_next = PPRB_IDLE;
                          else if (trig) state_next = PPRB_RUN;
            PPRB_RUN:     if (stop) state_next = PPRB_IDLE;
                          else if (underrun) state_next = PPRB_STOPPED;
            PPRB_STOPPED: if (start) state_next = PPRB_ARMED;
            default:      state_next = PPRB_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg    <= PPRB_IDLE;
            rptr_reg     <= '0;
            half_reg     <= 1'b0;
            full_reg     <= 2'b11;
            rd_valid_reg <= 1'b0;
            out_valid    <= 1'b0;
            out_word0    <= 16'h0000;
            out_word1    <= 16'h0000;
            refill_irq   <= 1'b0;
            overrun      <= 1'b0;
            running      <= 1'b0;
        end else begin
            state_reg    <= state_next;
            running      <= (state_next == PPRB_RUN);
            rd_valid_reg <= step && !underrun;
            out_valid    <= rd_valid_reg;
            out_word0    <= rd0;
            out_word1    <= rd1;
            refill_irq   <= half_end && !underrun;
            if (state_reg != PPRB_RUN && state_next == PPRB_ARMED) begin
                rptr_reg <= '0;
                half_reg <= 1'b0;
                full_reg <= 2'b11;
                overrun  <= 1'b0;
            end else if (step && !underrun) begin
                rptr_reg <= rptr_reg + 1'b1;
                if (half_end) begin
                    half_reg <= ~half_reg;
                end
            end
            // refill of the idle half; drain of the active half wins on the same half
            if (refill_done) begin
                full_reg[~half_reg] <= 1'b1;
            end
            if (half_end && !underrun) begin
                full_reg[half_reg] <= 1'b0;
            end
            if (underrun) begin
                overrun <= 1'b1;
            end
        end
    end

    assign active_half = half_reg;

    property p_irq_at_end;
        @(posedge sys_clk) disable iff (!rstn)
        (half_end && !underrun) |=> refill_irq;
    endproperty
    a_irq_at_end: assert property (p_irq_at_end) else $error("no refill pulse at half end");

    property p_switch;
        @(posedge sys_clk) disable iff (!rstn)
        (half_end && !underrun && !stop) |=> (half_reg != $past(half_reg)) && (rptr_reg == '0);
    endproperty
    a_switch: assert property (p_switch) else $error("half did not switch");

    property p_overrun_stop;
        @(posedge sys_clk) disable iff (!rstn)
        (underrun && !stop) |=> overrun && state_reg == PPRB_STOPPED;
    endproperty
    a_overrun_stop: assert property (p_overrun_stop) else $error("overrun did not stop");

    property p_overrun_hold;
        @(posedge sys_clk) disable iff (!rstn)
        (state_reg == PPRB_STOPPED && !start) |=> overrun;
    endproperty
    a_overrun_hold: assert property (p_overrun_hold) else $error("overrun flag lost");

    property p_wait_trig;
        @(posedge sys_clk) disable iff (!rstn)
        (state_reg == PPRB_ARMED && !trig) |=> state_reg != PPRB_RUN;
    endproperty
    a_wait_trig: assert property (p_wait_trig) else $error("ran without trigger");

    property p_gate;
        @(posedge sys_clk) disable iff (!rstn)
        (running && !gate_s2) |=> ##1 !out_valid;
    endproperty
    a_gate: assert property (p_gate) else $error("output while gate closed");

    property p_byte_pack;
        @(posedge sys_clk) disable iff (!rstn)
        (mem_we0 && memchan0_byte_samples) |-> packed_word[15:8] == wr_sample[7:0];
    endproperty
    a_byte_pack: assert property (p_byte_pack) else $error("byte packing wrong");

    property p_word_pack;
        @(posedge sys_clk) disable iff (!rstn)
        (wr_valid && !wr_byte_mode) |-> mem_we0 || mem_we1;
    endproperty
    a_word_pack: assert property (p_word_pack) else $error("word sample not stored");

    property p_continuous;
        @(posedge sys_clk) disable iff (!rstn)
        (step && !underrun) |=> ##1 out_valid;
    endproperty
    a_continuous: assert property (p_continuous) else $error("replay gap");
endmodule // pprb_top

// >>> verification/pprb_host.sv
// host-side model that refills a drained half when asked
`timescale 1ns/1ns
module pprb_host (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic refill_irq,
    input  wire logic slow,
    output logic      refill_done
);
    initial begin
        refill_done = 1'b0;
        forever begin
            @(negedge sys_clk);
            if (rstn === 1'b1 && refill_irq === 1'b1) begin
                // a slow host lets the active half drain before refilling the idle half
                repeat (slow ? 40 : 0) @(negedge sys_clk);
                refill_done = 1'b1;
                @(negedge sys_clk);
                refill_done = 1'b0;
            end
        end
    end
endmodule // pprb_host

// >>> verification/pprb_top_tb.sv
// testbench for the replay path with packing and ping-pong replay
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fails++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module pprb_top_tb;
    localparam int AW = 4;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        memchan0_byte_samples = 1'b1;
    logic        memchan1_byte_samples = 1'b0;
    logic        wr_valid = 1'b0;
    logic        wr_chan = 1'b0;
    logic [15:0] wr_sample = 16'h0000;
    logic        refill_done;
    logic        start = 1'b0;
    logic        stop = 1'b0;
    logic        sw_trigger = 1'b0;
    logic        ext_trigger = 1'b0;
    logic        gate = 1'b0;
    logic        slow = 1'b0;
    logic        out_valid, active_half, refill_irq, overrun, running;
    logic [15:0] out_word0, out_word1;
    int          fails = 0;
    int          checks = 0;
    int          n, k, irqs;

    pprb_top #(.AW(AW)) dut (.sys_clk(sys_clk), .rstn(rstn), .memchan0_byte_samples(memchan0_byte_samples),
        .memchan1_byte_samples(memchan1_byte_samples), .wr_valid(wr_valid), .wr_chan(wr_chan),
        .wr_sample(wr_sample), .refill_done(refill_done), .start(start), .stop(stop), .sw_trigger(sw_trigger),
        .ext_trigger(ext_trigger), .gate(gate), .out_valid(out_valid), .out_word0(out_word0),
        .out_word1(out_word1), .active_half(active_half), .refill_irq(refill_irq), .overrun(overrun),
        .running(running));
    pprb_host host (.sys_clk(sys_clk), .rstn(rstn), .refill_irq(refill_irq), .slow(slow),
        .refill_done(refill_done));

    // one word pair is replayed per sys_clk cycle while the gate is open
    always #5 sys_clk = ~sys_clk;

    function automatic logic [15:0] exp0(input int i);
        return {8'hA0 + 8'(2 * i + 1), 8'hA0 + 8'(2 * i)};
    endfunction
    function automatic logic [15:0] exp1(input int i);
        return 16'h5C00 + 16'(i) * 16'h0111;
    endfunction

    task automatic wr(input logic ch, input logic [15:0] s);
        @(negedge sys_clk);
        wr_valid = 1'b1;
        wr_chan = ch;
        wr_sample = s;
        @(negedge sys_clk);
        wr_valid = 1'b0;
    endtask

    task automatic pulse(input int which);
        @(negedge sys_clk);
        case (which)
            0: start = 1'b1;
            1: stop = 1'b1;
            default: sw_trigger = 1'b1;
        endcase
        @(negedge sys_clk);
        start = 1'b0;
        stop = 1'b0;
        sw_trigger = 1'b0;
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #50000;
        fails++;
        wrap_up;
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK({out_valid, refill_irq, overrun, running, active_half}, 5'h00)
        rstn = 1'b1;
        // high byte carries junk that byte packing must drop
        for (k = 0; k < 32; k++) wr(1'b0, {8'hFF, 8'hA0 + 8'(k)});
        for (k = 0; k < 16; k++) wr(1'b1, exp1(k));
        gate = 1'b1;
        pulse(0);
        repeat (8) @(negedge sys_clk);
        `CHK(running, 1'b0)
        pulse(2);
        for (n = 0; n < 20 && out_valid !== 1'b1; n++) @(negedge sys_clk);
        irqs = 0;
        for (k = 0; k < 24; k++) begin
            `CHK(out_valid, 1'b1)
            `CHK(out_word0, exp0(k % 16))
            `CHK(out_word1, exp1(k % 16))
            `CHK(active_half, 1'((k + 2) / 8))
            if (refill_irq === 1'b1) irqs++;
            @(negedge sys_clk);
        end
        `CHK(irqs, 3)
        `CHK(overrun, 1'b0)
        gate = 1'b0;
        repeat (5) @(negedge sys_clk);
        `CHK(out_valid, 1'b0)
        gate = 1'b1;
        for (n = 0; n < 20 && out_valid !== 1'b1; n++) @(negedge sys_clk);
        `CHK(out_valid, 1'b1)
        pulse(1);
        repeat (4) @(negedge sys_clk);
        `CHK(running, 1'b0)
        $display("test replay and packing done");
        slow = 1'b1;
        pulse(0);
        ext_trigger = 1'b1;
        for (n = 0; n < 20 && running !== 1'b1; n++) @(negedge sys_clk);
        `CHK(running, 1'b1)
        ext_trigger = 1'b0;
        for (n = 0; n < 100 && overrun !== 1'b1; n++) @(negedge sys_clk);
        `CHK(overrun, 1'b1)
        repeat (4) @(negedge sys_clk);
        `CHK({overrun, running}, 2'b10)
        slow = 1'b0;
        pulse(0);
        `CHK(overrun, 1'b0)
        pulse(1);
        $display("test overrun done");
        // swap sample widths: channel 0 holds words, channel 1 holds bytes
        memchan0_byte_samples = 1'b0;
        memchan1_byte_samples = 1'b1;
        for (k = 0; k < 16; k++) wr(1'b0, exp1(k));
        for (k = 0; k < 32; k++) wr(1'b1, {8'hFF, 8'hA0 + 8'(k)});
        pulse(0);
        pulse(2);
        for (n = 0; n < 20 && out_valid !== 1'b1; n++) @(negedge sys_clk);
        for (k = 0; k < 16; k++) begin
            `CHK(out_valid, 1'b1)
            `CHK(out_word0, exp1(k))
            `CHK(out_word1, exp0(k))
            @(negedge sys_clk);
        end
        pulse(1);
        $display("test swapped widths done");
        wrap_up;
    end
endmodule // pprb_top_tb
